// [hw/edt_pkg.sv]
// ----------------------------------------------------------------------------
// Energy-detect threshold constants
// ----------------------------------------------------------------------------
package edt_pkg;

   // Register location on the management register port
   localparam logic [4:0]  EDT_ADDR        = 5'h1D;

   // Field positions inside the 16-bit control word
   localparam int          BIT_EN          = 15;
   localparam int          BIT_AUTO_UP     = 14;
   localparam int          BIT_AUTO_DOWN   = 13;
   localparam int          BIT_MAN         = 12;
   localparam int          BIT_BURST_DIS   = 11;
   localparam int          BIT_PWR_STATE   = 10;
   localparam int          BIT_ERR_MET     = 9;
   localparam int          BIT_DATA_MET    = 8;
   localparam int          ERR_THR_LSB     = 4;
   localparam int          DATA_THR_LSB    = 0;
   localparam int          THR_W           = 4;

   // Reset values of the writable fields
   localparam logic [3:0]  THR_RESET       = 4'h1;
   localparam logic        EN_RESET        = 1'b0;
   localparam logic        AUTO_UP_RESET   = 1'b1;
   localparam logic        AUTO_DOWN_RESET = 1'b1;
   localparam logic        BURST_RESET     = 1'b0;

   // Event counters saturate here
   localparam logic [3:0]  CNT_MAX         = 4'hF;

   // Idle timeout: seconds as given, cycles derived from the clock rate
   localparam longint unsigned CLK_HZ              = 250_000_000;
   localparam longint unsigned IDLE_TIMEOUT_S      = 2;
   localparam longint unsigned IDLE_TIMEOUT_CYCLES = IDLE_TIMEOUT_S * CLK_HZ;

   // Power state of the energy-detect logic
   typedef enum logic [0:0] {
      EDT_DOWN = 1'b0,
      EDT_UP   = 1'b1
   } edt_pwr_t;

endpackage

// [hw/edt_cnt_if.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Link between the threshold logic and one event counter
// ----------------------------------------------------------------------------
interface edt_cnt_if;
   logic       inc;    // One event this cycle
   logic       clr;    // Restart the count
   logic [3:0] count;  // Current saturated count

   modport ctrl (output inc, output clr, input count);
   modport cnt  (input inc, input clr, output count);
endinterface

// [hw/edt_counter.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Saturating 4-bit event counter
// ----------------------------------------------------------------------------
module edt_counter
   import edt_pkg::*;
(
   input  wire logic clk,
   input  wire logic nrst,
   edt_cnt_if.cnt    bus
);
   logic [3:0] count;       // Held count
   logic [3:0] next_count;  // Value for the next edge

   // Clear wins over an event so a restart is never half done
   always_comb begin
      next_count = count;
      if (bus.clr) begin
         next_count = 4'h0;
      end else if (bus.inc && (count != CNT_MAX)) begin
         // Saturate rather than wrap, a wrap would hide a met threshold
         next_count = count + 4'h1;
      end
   end

   // Register only
   always_ff @(posedge clk) begin
      if (!nrst) begin
         count <= 4'h0;
      end else begin
         count <= next_count;
      end
   end

   assign bus.count = count;
endmodule

// [hw/edt_thresholds.sv]
`timescale 1ns/100ps
// Contract
// - Power-state bit reads one when powered up
// - Power-state bit meaningless while mode disabled
// - Error-met flag bit 9, clear-on-read, informational
// - Data-met flag bit 8 sets at threshold
// - Error threshold bits 7:4, default 0001
// - Data threshold bits 3:0, default 0001
// - Counters restart after two idle seconds
// - Enable bit 15 clear blocks power actions
// - Auto power-up bit 14 starts power-up
// - Auto power-down bit 13 starts power-down
module edt_thresholds
   import edt_pkg::*;
#(
   parameter longint unsigned TIMEOUT_CYCLES = edt_pkg::IDLE_TIMEOUT_CYCLES
)
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic [4:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [15:0] reg_wdata,
   output logic      [15:0] reg_rdata,
   input  wire logic        ed_data_event,
   input  wire logic        ed_err_event,
   input  wire logic        line_no_energy,
   output logic             power_up_start,
   output logic             power_down_start,
   output logic             burst_disable,
   output logic             line_power_state
);
   import edt_pkg::*;

   // ------------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------------
   localparam logic [31:0] TMO_LAST = 32'(TIMEOUT_CYCLES - 1);

   logic              line_energy_enable;          // Mode allowed
   logic              auto_power_up;               // Power up on data threshold
   logic              auto_power_down;             // Power down on no energy
   logic              burst_dis;                   // Stored, drives the pulser
   logic [3:0]        error_threshold;             // Error events needed
   logic [3:0]        data_threshold;              // Data events needed
   logic              error_threshold_met;         // Sticky, clear on read
   logic              data_threshold_met;          // Sticky, clear on read
   edt_pwr_t          pwr;                         // Energy-detect power state
   logic [31:0]       idle_cnt;                    // Cycles since last data event or expiry
   logic [15:0]       rdata;                       // Read data register

   logic              next_line_energy_enable;
   logic              next_auto_power_up;
   logic              next_auto_power_down;
   logic              next_burst_dis;
   logic [3:0]        next_error_threshold;
   logic [3:0]        next_data_threshold;
   logic              next_error_threshold_met;
   logic              next_data_threshold_met;
   edt_pwr_t          next_pwr;
   logic [31:0]       next_idle_cnt;
   logic [15:0]       next_rdata;

   logic              rd_hit;                      // Read of this register
   logic              wr_hit;                      // Write of this register
   logic              man_req;                     // Manual toggle request
   logic              data_hit;                    // Data threshold reached now
   logic              err_hit;                     // Error threshold reached now
   logic              idle_done;                   // Idle timeout expired
   logic              go_up;                       // Power-up starts
   logic              go_down;                     // Power-down starts

   edt_cnt_if         cnt_bus [2] ();              // 0 = data, 1 = error

   // Address decode, shared by read and write
   function automatic logic addr_match(input logic [4:0] a);
      return a == EDT_ADDR;
   endfunction

   // True when one more event lifts the count to the threshold or beyond
   function automatic logic reaches(input logic [3:0] cnt, input logic [3:0] thr);
      return ({1'b0, cnt} + 5'h01) >= {1'b0, thr};
   endfunction

   // ------------------------------------------------------------------------
   // Event counters
   // ------------------------------------------------------------------------
   // Both counters restart together on timeout or on any power action
   generate
      for (genvar i = 0; i < 2; i++) begin : g_cnt
         edt_counter u_cnt (
            .clk  (clk),
            .nrst (nrst),
            .bus  (cnt_bus[i])
         );
         assign cnt_bus[i].clr = idle_done || go_up || go_down;
      end
   endgenerate

   assign cnt_bus[0].inc = ed_data_event;
   assign cnt_bus[1].inc = ed_err_event;

   // ------------------------------------------------------------------------
   // Decode and event terms
   // ------------------------------------------------------------------------
   always_comb begin
      rd_hit    = reg_rd && addr_match(reg_addr);
      wr_hit    = reg_wr && addr_match(reg_addr);
      man_req   = wr_hit && reg_wdata[BIT_MAN];
      data_hit  = ed_data_event && reaches(cnt_bus[0].count, data_threshold);
      err_hit   = ed_err_event && reaches(cnt_bus[1].count, error_threshold);
      // A data event restarts the idle window, so it never meets the timeout
      idle_done = !ed_data_event && (idle_cnt == TMO_LAST);
      // Error threshold feeds only its flag, never a power action
      go_up     = 1'b0;
      go_down   = 1'b0;
      if (line_energy_enable) begin
         unique case (pwr)
            EDT_DOWN: go_up   = man_req || (auto_power_up && data_hit);
            EDT_UP:   go_down = man_req || (auto_power_down && line_no_energy);
         endcase
      end
   end

   // ------------------------------------------------------------------------
   // Register file, flags, power state and idle timer: next values
   // ------------------------------------------------------------------------
   always_comb begin
      next_line_energy_enable = line_energy_enable;
      next_auto_power_up      = auto_power_up;
      next_auto_power_down    = auto_power_down;
      next_burst_dis          = burst_dis;
      next_error_threshold    = error_threshold;
      next_data_threshold     = data_threshold;
      next_pwr                = pwr;
      next_rdata              = rdata;
      // Writes land on the writable fields only; bit 12 self-clears
      if (wr_hit) begin
         next_line_energy_enable = reg_wdata[BIT_EN];
         next_auto_power_up      = reg_wdata[BIT_AUTO_UP];
         next_auto_power_down    = reg_wdata[BIT_AUTO_DOWN];
         next_burst_dis          = reg_wdata[BIT_BURST_DIS];
         next_error_threshold    = reg_wdata[ERR_THR_LSB +: THR_W];
         next_data_threshold     = reg_wdata[DATA_THR_LSB +: THR_W];
      end
      // Clear on read, but a new hit in the same cycle keeps the flag
      next_error_threshold_met = err_hit || (error_threshold_met && !rd_hit);
      next_data_threshold_met  = data_hit || (data_threshold_met && !rd_hit);
      // Sequencing itself is outside; the state follows the start pulses
      if (go_up) begin
         next_pwr = EDT_UP;
      end else if (go_down) begin
         next_pwr = EDT_DOWN;
      end
      // Idle timer restarts on data events and on its own expiry
      if (ed_data_event || idle_done) begin
         next_idle_cnt = 32'h0;
      end else begin
         next_idle_cnt = idle_cnt + 32'h1;
      end
      // Read snapshot; the state bit is valid only with the mode enabled
      if (rd_hit) begin
         next_rdata                             = 16'h0000;
         next_rdata[BIT_EN]                     = line_energy_enable;
         next_rdata[BIT_AUTO_UP]                = auto_power_up;
         next_rdata[BIT_AUTO_DOWN]              = auto_power_down;
         next_rdata[BIT_BURST_DIS]              = burst_dis;
         next_rdata[BIT_PWR_STATE]              = (pwr == EDT_UP);
         next_rdata[BIT_ERR_MET]                = error_threshold_met;
         next_rdata[BIT_DATA_MET]               = data_threshold_met;
         next_rdata[ERR_THR_LSB +: THR_W]       = error_threshold;
         next_rdata[DATA_THR_LSB +: THR_W]      = data_threshold;
      end
   end

   // ------------------------------------------------------------------------
   // Register only
   // ------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         line_energy_enable  <= EN_RESET;
         auto_power_up       <= AUTO_UP_RESET;
         auto_power_down     <= AUTO_DOWN_RESET;
         burst_dis           <= BURST_RESET;
         error_threshold     <= THR_RESET;
         data_threshold      <= THR_RESET;
         error_threshold_met <= 1'b0;
         data_threshold_met  <= 1'b0;
         pwr                 <= EDT_DOWN;
         idle_cnt            <= 32'h0;
         rdata               <= 16'h0000;
      end else begin
         line_energy_enable  <= next_line_energy_enable;
         auto_power_up       <= next_auto_power_up;
         auto_power_down     <= next_auto_power_down;
         burst_dis           <= next_burst_dis;
         error_threshold     <= next_error_threshold;
         data_threshold      <= next_data_threshold;
         error_threshold_met <= next_error_threshold_met;
         data_threshold_met  <= next_data_threshold_met;
         pwr                 <= next_pwr;
         idle_cnt            <= next_idle_cnt;
         rdata               <= next_rdata;
      end
   end

   // ------------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------------
   assign reg_rdata        = rdata;
   assign power_up_start   = go_up;
   assign power_down_start = go_down;
   assign burst_disable    = burst_dis;
   assign line_power_state = (pwr == EDT_UP);

   // ------------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------------
   a_state_read:
   assert property (@(posedge clk) disable iff (!nrst)
      rd_hit |=> reg_rdata[BIT_PWR_STATE] == $past(line_power_state))
      else $error("power state bit does not match state");

   a_err_met_clr:
   assert property (@(posedge clk) disable iff (!nrst)
      (rd_hit && !err_hit) |=> !error_threshold_met ##1 (error_threshold_met || !$past(err_hit)))
      else $error("error met flag not cleared by read");

   a_data_met_set:
   assert property (@(posedge clk) disable iff (!nrst)
      data_hit |=> data_threshold_met
         && (({1'b0, $past(cnt_bus[0].count)} + 5'h01) >= {1'b0, $past(data_threshold)}))
      else $error("data met flag not set at threshold");

   a_thr_reset:
   assert property (@(posedge clk)
      $rose(nrst) |-> (error_threshold == 4'h1) && (data_threshold == 4'h1) && !data_threshold_met)
      else $error("thresholds not at reset value");

   a_data_thr_wr:
   assert property (@(posedge clk) disable iff (!nrst)
      wr_hit |=> data_threshold == $past(reg_wdata[3:0]) && error_threshold == $past(reg_wdata[7:4]))
      else $error("threshold write not taken");

   a_idle_restart:
   assert property (@(posedge clk) disable iff (!nrst)
      idle_done |=> (cnt_bus[0].count == 4'h0) && (cnt_bus[1].count == 4'h0) && (idle_cnt == 32'h0))
      else $error("counters not restarted after idle timeout");

   a_no_act_dis:
   assert property (@(posedge clk) disable iff (!nrst)
      !line_energy_enable |-> !power_up_start && !power_down_start ##1 $stable(line_power_state))
      else $error("power action while disabled");

   a_auto_up:
   assert property (@(posedge clk) disable iff (!nrst)
      (line_energy_enable && auto_power_up && data_hit && !line_power_state)
         |-> power_up_start ##1 line_power_state)
      else $error("auto power up missing");

   a_auto_down:
   assert property (@(posedge clk) disable iff (!nrst)
      (line_energy_enable && auto_power_down && line_no_energy && line_power_state)
         |-> power_down_start ##1 !line_power_state)
      else $error("auto power down missing");

   a_set_wins:
   assert property (@(posedge clk) disable iff (!nrst)
      (rd_hit && (data_hit || err_hit))
         |=> (data_threshold_met || !$past(data_hit)) && (error_threshold_met || !$past(err_hit)))
      else $error("event lost during clearing read");

endmodule

// [sim/tb_top.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Self-checking bench for the energy-detect threshold block
// ----------------------------------------------------------------------------
module tb_top;
   import edt_pkg::*;

   // ----------------------------------------------------------------------------
   // Stimulus and observation signals
   // ----------------------------------------------------------------------------
   logic        clk;               // 250 MHz management clock
   logic        nrst;              // Synchronous reset, active low
   logic [4:0]  reg_addr;          // Register address
   logic        reg_wr;            // Write strobe
   logic        reg_rd;            // Read strobe
   logic [15:0] reg_wdata;         // Write data
   logic [15:0] reg_rdata;         // Read data
   logic        ed_data_event;     // Data event pulse
   logic        ed_err_event;      // Error event pulse
   logic        line_no_energy;    // Line idle level
   logic        power_up_start;    // Power-up start pulse
   logic        power_down_start;  // Power-down start pulse
   logic        burst_disable;     // Burst disable level
   logic        line_power_state;  // Power state level
   logic [15:0] up_cnt;            // Power-up pulses seen
   logic [15:0] dn_cnt;            // Power-down pulses seen
   int          miscompares;       // Failed comparisons
   int          tests_run;         // Comparisons made

   // Short idle timeout so the restart can be seen in a brief run
   edt_thresholds #(.TIMEOUT_CYCLES(20)) i_dut (
      .clk              (clk),
      .nrst             (nrst),
      .reg_addr         (reg_addr),
      .reg_wr           (reg_wr),
      .reg_rd           (reg_rd),
      .reg_wdata        (reg_wdata),
      .reg_rdata        (reg_rdata),
      .ed_data_event    (ed_data_event),
      .ed_err_event     (ed_err_event),
      .line_no_energy   (line_no_energy),
      .power_up_start   (power_up_start),
      .power_down_start (power_down_start),
      .burst_disable    (burst_disable),
      .line_power_state (line_power_state)
   );

   // Clock generator
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Count start pulses at the edge, before registered state moves on
   always @(posedge clk) begin
      if (nrst !== 1'b1) begin
         up_cnt <= 16'h0000;
         dn_cnt <= 16'h0000;
      end else begin
         up_cnt <= up_cnt + {15'h0, power_up_start};
         dn_cnt <= dn_cnt + {15'h0, power_down_start};
      end
   end

   // ----------------------------------------------------------------------------
   // Access tasks; each starts and ends 1 ns after a rising edge
   // ----------------------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   // One write, then a quiet cycle so the strobe is never raised twice in a step
   task automatic wr(input logic [4:0] addr, input logic [15:0] data);
      reg_addr  = addr;
      reg_wdata = data;
      reg_wr    = 1'b1;
      @(posedge clk);
      #1 reg_wr = 1'b0;
      @(posedge clk);
      #1;
   endtask

   // One read, optionally with a data event in the same cycle
   task automatic rd(input logic [4:0] addr, input logic dev, input logic [15:0] exp, input string msg);
      reg_addr      = addr;
      reg_rd        = 1'b1;
      ed_data_event = dev;
      @(posedge clk);
      #1 reg_rd = 1'b0;
      ed_data_event = 1'b0;
      chk(reg_rdata, exp, msg);
      @(posedge clk);
      #1;
   endtask

   // Send n events, one every second cycle
   task automatic ev(input logic d, input logic e, input int n);
      repeat (n) begin
         ed_data_event = d;
         ed_err_event  = e;
         @(posedge clk);
         #1 ed_data_event = 1'b0;
         ed_err_event  = 1'b0;
         @(posedge clk);
         #1;
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // The single place where the run ends
   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Watchdog against a hung sequence
   initial begin
      #100000;
      miscompares++;
      complete_run();
   end

   // ----------------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------------
   initial begin
      nrst = 1'b0; reg_addr = 5'h00; reg_wr = 1'b0; reg_rd = 1'b0; reg_wdata = 16'h0000;
      ed_data_event = 1'b0; ed_err_event = 1'b0; line_no_energy = 1'b0;
      miscompares = 0; tests_run = 0;
      repeat (16) @(posedge clk);
      #1 nrst = 1'b1;
      // Reset values, then foreign address, read-only and manual bits are ignored
      rd(EDT_ADDR, 1'b0, 16'h6011, "reset value");
      wr(5'h1C, 16'hFFFF);
      wr(EDT_ADDR, 16'h7711);
      rd(EDT_ADDR, 1'b0, 16'h6011, "read-only bits");
      rd(5'h1C, 1'b0, 16'h6011, "foreign read holds data");
      $display("test registers done");
      // Thresholds met while disabled; flags clear on read, no power action
      wr(EDT_ADDR, 16'h6023);
      ev(1'b1, 1'b0, 2);
      rd(EDT_ADDR, 1'b0, 16'h6023, "below data threshold");
      ev(1'b1, 1'b0, 1);
      rd(EDT_ADDR, 1'b0, 16'h6123, "data threshold met");
      rd(EDT_ADDR, 1'b0, 16'h6023, "data flag cleared");
      ev(1'b0, 1'b1, 2);
      rd(EDT_ADDR, 1'b0, 16'h6223, "error threshold met");
      rd(EDT_ADDR, 1'b0, 16'h6023, "error flag cleared");
      chk(up_cnt, 16'h0000, "no power-up while disabled");
      $display("test thresholds done");
      // Event in the same cycle as the clearing read
      wr(EDT_ADDR, 16'h6011);
      rd(EDT_ADDR, 1'b0, 16'h6011, "flags clear");
      rd(EDT_ADDR, 1'b1, 16'h6011, "snapshot before event");
      rd(EDT_ADDR, 1'b0, 16'h6111, "event kept over clear");
      $display("test read collision done");
      // Idle restart of the counts, gaps one cycle short of and at the timeout
      wr(EDT_ADDR, 16'h6012);
      idle(25);
      ev(1'b1, 1'b0, 1);
      idle(18);
      ev(1'b1, 1'b0, 1);
      rd(EDT_ADDR, 1'b0, 16'h6112, "gap just inside timeout accumulates");
      idle(25);
      ev(1'b1, 1'b0, 1);
      idle(19);
      ev(1'b1, 1'b0, 1);
      rd(EDT_ADDR, 1'b0, 16'h6012, "gap at timeout restarts count");
      $display("test idle restart done");
      // Power actions with the mode enabled
      wr(EDT_ADDR, 16'hE021);
      idle(25);
      ev(1'b0, 1'b1, 2);
      rd(EDT_ADDR, 1'b0, 16'hE221, "error met, still down");
      chk(up_cnt, 16'h0000, "error met takes no action");
      ev(1'b1, 1'b0, 1);
      chk(up_cnt, 16'h0001, "automatic power-up");
      chk({15'h0, line_power_state}, 16'h0001, "state pin up");
      rd(EDT_ADDR, 1'b0, 16'hE521, "state up, data met");
      line_no_energy = 1'b1;
      idle(3);
      line_no_energy = 1'b0;
      chk(dn_cnt, 16'h0001, "one automatic power-down");
      rd(EDT_ADDR, 1'b0, 16'hE021, "state down");
      chk({15'h0, burst_disable}, 16'h0000, "burst disable level");
      wr(EDT_ADDR, 16'hA821);
      chk({15'h0, burst_disable}, 16'h0001, "burst disable set");
      ev(1'b1, 1'b0, 1);
      chk(up_cnt, 16'h0001, "no power-up without auto");
      rd(EDT_ADDR, 1'b0, 16'hA921, "flag set without auto");
      // Manual bit flips the state once per write and always reads zero
      wr(EDT_ADDR, 16'hB821);
      chk(up_cnt, 16'h0002, "manual power-up");
      rd(EDT_ADDR, 1'b0, 16'hAC21, "state up, manual bit clear");
      wr(EDT_ADDR, 16'hB821);
      chk(dn_cnt, 16'h0002, "manual power-down");
      chk({15'h0, line_power_state}, 16'h0000, "state pin down");
      rd(EDT_ADDR, 1'b0, 16'hA821, "state down after manual");
      $display("test power actions done");
      complete_run();
   end
endmodule
